/* core/ssa_annunciator.sv */
// station status annunciator: lamp sequence, status lamps and audible alarms
//
// Summary of operation
// RQ1 - all lamps on three seconds, health yellow
// RQ2 - then all lamps dark fifteen seconds
// RQ3 - then health red alone six seconds
// RQ4 - major failure shows steady red
// RQ5 - minor failure shows flashing red
// RQ6 - no condition shows steady green
// RQ7 - boot mode alternates red and green
// RQ8 - service mode flashes green
// RQ9 - major: unlock, amp fail, sharp cutback, selftest
// RQ10 - minor: mains, metering, loopback, bad channel
// RQ11 - service: any of six maintenance conditions
// RQ12 - receive lamp green while unsquelched
// RQ13 - trunking without controller data flashes fallback
// RQ14 - amp lamp steady keyed, flashing with cutback
// RQ15 - mains loss with fallover gives one beep
// RQ16 - keyed amplifier failure gives two beeps
// RQ17 - each alarm pattern repeats every ten seconds
// RQ18 - coincident alarms start two seconds apart
// RQ19 - health priority: boot, major, minor, service, green
// RQ20 - one shared configurable half-duty blink
//
// Design decisions made here: strobed register access and the register offsets.
`include "ssa_regs.svh"
`default_nettype none
module ssa_annunciator #(
    parameter int TICK_CYCLES = `SSA_CLK_HZ / 1000 * `SSA_TICK_MS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire ssa_pkg::ssa_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output var ssa_pkg::ssa_word_t reg_rdata,
    // major failure sources
    input wire logic rx_synth_unlock,
    input wire logic tx_synth_unlock,
    input wire logic amp_fail,
    input wire logic sharp_cutback,
    input wire logic self_test_fail,
    // minor failure sources
    input wire logic mains_loss,
    input wire logic exciter_meter_low,
    input wire logic receiver_meter_low,
    input wire logic loopback_fail,
    input wire logic invalid_channel,
    // service conditions
    input wire logic intercom,
    input wire logic access_disable,
    input wire logic power_control_disable,
    input wire logic tone_squelch_disable,
    input wire logic fallback_disable,
    input wire logic service_transmit_key,
    // station activity
    input wire logic boot_mode,
    input wire logic rx_unsquelched,
    input wire logic trunk_tx_data,
    input wire logic amp_keyed,
    input wire logic power_cutback,
    // lamps and speaker
    output logic health_red,
    output logic health_green,
    output logic rx_active_led,
    output logic fallback_led,
    output logic amplifier_keyed_indicator,
    output logic speaker_beep
);
    import ssa_pkg::*;

    localparam int CW = `SSA_CNT_W;
    localparam logic [CW-1:0] LAMP_T = CW'(`SSA_LAMP_TEST_MS / `SSA_TICK_MS);
    localparam logic [CW-1:0] DARK_T = CW'(`SSA_DARK_MS / `SSA_TICK_MS);
    localparam logic [CW-1:0] RED_T = CW'(`SSA_RED_MS / `SSA_TICK_MS);
    localparam logic [CW-1:0] REP_T = CW'(`SSA_ALARM_REPEAT_MS / `SSA_TICK_MS);
    localparam logic [CW-1:0] STAG_T = CW'(`SSA_ALARM_STAGGER_MS / `SSA_TICK_MS);
    localparam logic [CW-1:0] BEEP_T = CW'(`SSA_BEEP_MS / `SSA_TICK_MS);
    localparam logic [CW-1:0] FB_T = CW'(`SSA_FALLBACK_MS / `SSA_TICK_MS);

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [`SSA_NIN-1:0] pin_vec;
    logic [`SSA_NIN-1:0] meta_q;
    logic [`SSA_NIN-1:0] sync_q;

    assign pin_vec[`SSA_IN_RX_UNLOCK] = rx_synth_unlock;
    assign pin_vec[`SSA_IN_TX_UNLOCK] = tx_synth_unlock;
    assign pin_vec[`SSA_IN_AMP_FAIL] = amp_fail;
    assign pin_vec[`SSA_IN_SHARP_CUT] = sharp_cutback;
    assign pin_vec[`SSA_IN_SELFTEST] = self_test_fail;
    assign pin_vec[`SSA_IN_MAINS] = mains_loss;
    assign pin_vec[`SSA_IN_EXC_METER] = exciter_meter_low;
    assign pin_vec[`SSA_IN_RX_METER] = receiver_meter_low;
    assign pin_vec[`SSA_IN_LOOPBACK] = loopback_fail;
    assign pin_vec[`SSA_IN_BAD_CHAN] = invalid_channel;
    assign pin_vec[`SSA_IN_INTERCOM] = intercom;
    assign pin_vec[`SSA_IN_ACCESS] = access_disable;
    assign pin_vec[`SSA_IN_PWR_CTRL] = power_control_disable;
    assign pin_vec[`SSA_IN_SQUELCH] = tone_squelch_disable;
    assign pin_vec[`SSA_IN_FB_DIS] = fallback_disable;
    assign pin_vec[`SSA_IN_SVC_KEY] = service_transmit_key;
    assign pin_vec[`SSA_IN_BOOT] = boot_mode;
    assign pin_vec[`SSA_IN_RX_ACT] = rx_unsquelched;
    assign pin_vec[`SSA_IN_TRUNK_DATA] = trunk_tx_data;
    assign pin_vec[`SSA_IN_AMP_KEYED] = amp_keyed;
    assign pin_vec[`SSA_IN_CUTBACK] = power_cutback;

    for (genvar g = 0; g < `SSA_NIN; g++) begin : g_sync
        always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
                meta_q[g] <= 1'b0;
                sync_q[g] <= 1'b0;
            end else begin
                meta_q[g] <= pin_vec[g];
                sync_q[g] <= meta_q[g];
            end
        end
    end

    // ----------------------------------------
    // condition decode
    // ----------------------------------------
    logic major;
    logic minor;
    logic service;
    logic booting;

    assign major = sync_q[`SSA_IN_RX_UNLOCK] | sync_q[`SSA_IN_TX_UNLOCK]
        | sync_q[`SSA_IN_AMP_FAIL] | sync_q[`SSA_IN_SHARP_CUT]
        | sync_q[`SSA_IN_SELFTEST]; // [RQ9]
    assign minor = sync_q[`SSA_IN_MAINS] | sync_q[`SSA_IN_EXC_METER]
        | sync_q[`SSA_IN_RX_METER] | sync_q[`SSA_IN_LOOPBACK]
        | sync_q[`SSA_IN_BAD_CHAN]; // [RQ10]
    assign service = sync_q[`SSA_IN_INTERCOM] | sync_q[`SSA_IN_ACCESS]
        | sync_q[`SSA_IN_PWR_CTRL] | sync_q[`SSA_IN_SQUELCH]
        | sync_q[`SSA_IN_FB_DIS] | sync_q[`SSA_IN_SVC_KEY]; // [RQ11]
    assign booting = sync_q[`SSA_IN_BOOT];

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [1:0] ctrl_q;
    logic [7:0] blink_half_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= `SSA_CTRL_RST;
            blink_half_q <= `SSA_BLINK_RST;
        end else if (reg_wr && reg_addr == `SSA_ADDR_CTRL) begin
            ctrl_q <= reg_wdata[1:0];
        end else if (reg_wr && reg_addr == `SSA_ADDR_BLINK) begin
            blink_half_q <= reg_wdata[7:0]; // [RQ20]
        end
    end

    // ----------------------------------------
    // tick and blink
    // ----------------------------------------
    logic tick;
    logic [7:0] blink_cnt_q;
    logic blink_q;

    ssa_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .tick(tick)
    );

    // half period of zero behaves as one tick
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            blink_cnt_q <= 8'h00;
            blink_q <= 1'b0;
        end else if (tick) begin
            if (blink_cnt_q + 8'h01 >= blink_half_q) begin
                blink_cnt_q <= 8'h00;
                blink_q <= ~blink_q; // [RQ20]
            end else begin
                blink_cnt_q <= blink_cnt_q + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // trunking controller watchdog
    // ----------------------------------------
    logic data_prev_q;
    logic [CW-1:0] fb_cnt_q;
    logic fallback;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            data_prev_q <= 1'b0;
            fb_cnt_q <= '0;
        end else begin
            data_prev_q <= sync_q[`SSA_IN_TRUNK_DATA];
            if (data_prev_q != sync_q[`SSA_IN_TRUNK_DATA]) begin
                fb_cnt_q <= '0;
            end else if (tick && fb_cnt_q < FB_T) begin
                fb_cnt_q <= fb_cnt_q + 1'b1;
            end
        end
    end

    assign fallback = ctrl_q[`SSA_CTRL_TRUNK] && fb_cnt_q >= FB_T; // [RQ13]

    // ----------------------------------------
    // power-up lamp sequence
    // ----------------------------------------
    ssa_seq_t seq_q;
    logic [CW-1:0] seq_cnt_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            seq_q <= SEQ_LAMP;
            seq_cnt_q <= '0;
        end else if (tick && seq_q != SEQ_RUN) begin
            seq_cnt_q <= seq_cnt_q + 1'b1;
            case (seq_q)
                SEQ_LAMP: begin
                    if (seq_cnt_q == LAMP_T - 1'b1) begin
                        seq_q <= SEQ_DARK; // [RQ1]
                        seq_cnt_q <= '0;
                    end
                end
                SEQ_DARK: begin
                    if (seq_cnt_q == DARK_T - 1'b1) begin
                        seq_q <= SEQ_RED; // [RQ2]
                        seq_cnt_q <= '0;
                    end
                end
                SEQ_RED: begin
                    if (seq_cnt_q == RED_T - 1'b1) begin
                        seq_q <= SEQ_RUN; // [RQ3]
                        seq_cnt_q <= '0;
                    end
                end
                default: seq_q <= SEQ_RUN;
            endcase
        end
    end

    // ----------------------------------------
    // lamp drivers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            health_red <= 1'b0;
            health_green <= 1'b0;
            rx_active_led <= 1'b0;
            fallback_led <= 1'b0;
            amplifier_keyed_indicator <= 1'b0;
        end else begin
            case (seq_q)
                SEQ_LAMP: begin
                    health_red <= 1'b1; // [RQ1]
                    health_green <= 1'b1;
                    rx_active_led <= 1'b1;
                    fallback_led <= 1'b1;
                    amplifier_keyed_indicator <= 1'b1;
                end
                SEQ_RED: begin
                    health_red <= 1'b1; // [RQ3]
                    health_green <= 1'b0;
                    rx_active_led <= 1'b0;
                    fallback_led <= 1'b0;
                    amplifier_keyed_indicator <= 1'b0;
                end
                SEQ_RUN: begin
                    if (booting) begin
                        health_red <= blink_q; // [RQ7] [RQ19]
                        health_green <= ~blink_q;
                    end else if (major) begin
                        health_red <= 1'b1; // [RQ4]
                        health_green <= 1'b0;
                    end else if (minor) begin
                        health_red <= blink_q; // [RQ5]
                        health_green <= 1'b0;
                    end else if (service) begin
                        health_red <= 1'b0; // [RQ8]
                        health_green <= blink_q;
                    end else begin
                        health_red <= 1'b0; // [RQ6]
                        health_green <= 1'b1;
                    end
                    rx_active_led <= sync_q[`SSA_IN_RX_ACT]; // [RQ12]
                    fallback_led <= fallback & blink_q; // [RQ13]
                    amplifier_keyed_indicator <= sync_q[`SSA_IN_AMP_KEYED]
                        & (~sync_q[`SSA_IN_CUTBACK] | blink_q); // [RQ14]
                end
                default: begin
                    health_red <= 1'b0; // [RQ2]
                    health_green <= 1'b0;
                    rx_active_led <= 1'b0;
                    fallback_led <= 1'b0;
                    amplifier_keyed_indicator <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // audible alarm schedule
    // ----------------------------------------
    logic mains_alarm;
    logic amp_alarm;
    logic [CW-1:0] frame_q;
    logic start_one;
    logic start_two;

    assign mains_alarm = ctrl_q[`SSA_CTRL_FALLOVER] & sync_q[`SSA_IN_MAINS]
        & (seq_q == SEQ_RUN); // [RQ15]
    assign amp_alarm = sync_q[`SSA_IN_AMP_KEYED] & sync_q[`SSA_IN_AMP_FAIL]
        & (seq_q == SEQ_RUN); // [RQ16]

    // frame restarts at zero once no alarm is active
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            frame_q <= '0;
        end else if (!(mains_alarm || amp_alarm)) begin
            frame_q <= '0;
        end else if (tick) begin
            frame_q <= (frame_q == REP_T - 1'b1) ? '0 : frame_q + 1'b1; // [RQ17]
        end
    end

    // first active alarm at frame start, the amplifier one staggered after it
    assign start_one = tick && frame_q == '0 && (mains_alarm || amp_alarm);
    assign start_two = tick && frame_q == STAG_T && mains_alarm && amp_alarm; // [RQ18]

    // ----------------------------------------
    // beep generator
    // ----------------------------------------
    ssa_beep_t bst_q;
    logic [CW-1:0] beep_cnt_q;
    logic [1:0] beeps_left_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            bst_q <= BP_IDLE;
            beep_cnt_q <= '0;
            beeps_left_q <= 2'h0;
        end else if (start_one || start_two) begin
            bst_q <= BP_ON;
            beep_cnt_q <= '0;
            beeps_left_q <= (start_one && mains_alarm) ? 2'h1 : 2'h2; // [RQ15] [RQ16]
        end else if (tick) begin
            case (bst_q)
                BP_ON: begin
                    if (beep_cnt_q == BEEP_T - 1'b1) begin
                        bst_q <= BP_GAP;
                        beep_cnt_q <= '0;
                        beeps_left_q <= beeps_left_q - 2'h1;
                    end else begin
                        beep_cnt_q <= beep_cnt_q + 1'b1;
                    end
                end
                BP_GAP: begin
                    if (beep_cnt_q == BEEP_T - 1'b1) begin
                        bst_q <= (beeps_left_q != 2'h0) ? BP_ON : BP_IDLE;
                        beep_cnt_q <= '0;
                    end else begin
                        beep_cnt_q <= beep_cnt_q + 1'b1;
                    end
                end
                default: bst_q <= BP_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            speaker_beep <= 1'b0;
        end else begin
            speaker_beep <= (bst_q == BP_ON);
        end
    end

    // ----------------------------------------
    // register read
    // ----------------------------------------
    ssa_word_t status;

    always_comb begin
        status = '0;
        status[`SSA_ST_BOOT] = booting;
        status[`SSA_ST_MAJOR] = major;
        status[`SSA_ST_MINOR] = minor;
        status[`SSA_ST_SERVICE] = service;
        status[`SSA_ST_FALLBACK] = fallback;
        status[`SSA_ST_BEEP] = speaker_beep;
        status[`SSA_ST_SEQ_HI:`SSA_ST_SEQ_LO] = seq_q;
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                `SSA_ADDR_CTRL: reg_rdata <= {30'h0000_0000, ctrl_q};
                `SSA_ADDR_BLINK: reg_rdata <= {24'h00_0000, blink_half_q};
                `SSA_ADDR_STATUS: reg_rdata <= status;
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_lamp_test;
        @(posedge sys_clk) disable iff (!resetn)
        seq_q == SEQ_LAMP |=> health_red && health_green && rx_active_led
            && fallback_led && amplifier_keyed_indicator;
    endproperty
    a_lamp_test: assert property (p_lamp_test) // [RQ1]
        else $error("lamp test lamps not all lit");

    property p_dark;
        @(posedge sys_clk) disable iff (!resetn)
        seq_q == SEQ_DARK |=> !(health_red || health_green || rx_active_led
            || fallback_led || amplifier_keyed_indicator);
    endproperty
    a_dark: assert property (p_dark) // [RQ2]
        else $error("lamp lit during dark phase");

    property p_red_only;
        @(posedge sys_clk) disable iff (!resetn)
        seq_q == SEQ_RED |=> health_red && !health_green && !rx_active_led
            && !amplifier_keyed_indicator;
    endproperty
    a_red_only: assert property (p_red_only) // [RQ3]
        else $error("red phase shows wrong lamps");

    property p_seq_order;
        @(posedge sys_clk) disable iff (!resetn)
        $changed(seq_q) |-> $past(tick) && seq_q == ssa_seq_t'($past(seq_q) + 2'h1);
    endproperty
    a_seq_order: assert property (p_seq_order) // [RQ1]
        else $error("lamp sequence skipped a phase");

    property p_major;
        @(posedge sys_clk) disable iff (!resetn)
        seq_q == SEQ_RUN && !booting && major |=> health_red && !health_green;
    endproperty
    a_major: assert property (p_major) // [RQ4]
        else $error("major failure not steady red");

    property p_normal;
        @(posedge sys_clk) disable iff (!resetn)
        seq_q == SEQ_RUN && !(booting || major || minor || service)
            |=> health_green && !health_red;
    endproperty
    a_normal: assert property (p_normal) // [RQ6]
        else $error("normal state not steady green");

    property p_rx_lamp;
        @(posedge sys_clk) disable iff (!resetn)
        seq_q == SEQ_RUN |=> rx_active_led == $past(sync_q[`SSA_IN_RX_ACT]);
    endproperty
    a_rx_lamp: assert property (p_rx_lamp) // [RQ12]
        else $error("receive lamp does not follow squelch");

    property p_blink_tick;
        @(posedge sys_clk) disable iff (!resetn)
        $changed(blink_q) |-> $past(tick);
    endproperty
    a_blink_tick: assert property (p_blink_tick) // [RQ20]
        else $error("blink toggled off a tick");

    property p_stagger;
        @(posedge sys_clk) disable iff (!resetn)
        tick && frame_q == STAG_T && mains_alarm && amp_alarm
            |=> bst_q == BP_ON && beeps_left_q == 2'h2;
    endproperty
    a_stagger: assert property (p_stagger) // [RQ18]
        else $error("second alarm not staggered");

    property p_beep_count;
        @(posedge sys_clk) disable iff (!resetn)
        start_one && mains_alarm |=> beeps_left_q == 2'h1 && bst_q == BP_ON;
    endproperty
    a_beep_count: assert property (p_beep_count) // [RQ15]
        else $error("mains alarm not a single beep");

endmodule // ssa_annunciator
`default_nettype wire

/* core/ssa_regs.svh */
// constants for the station status annunciator: timing, register map, pin indices
`ifndef SSA_REGS_SVH
`define SSA_REGS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define SSA_CLK_HZ 50000000
`define SSA_TICK_MS 10
`define SSA_LAMP_TEST_MS 3000
`define SSA_DARK_MS 15000
`define SSA_RED_MS 6000
`define SSA_ALARM_REPEAT_MS 10000
`define SSA_ALARM_STAGGER_MS 2000
`define SSA_BEEP_MS 100
`define SSA_FALLBACK_MS 1000
`define SSA_CNT_W 11

// ----------------------------------------
// register map
// ----------------------------------------
`define SSA_ADDR_CTRL 8'h00
`define SSA_ADDR_BLINK 8'h04
`define SSA_ADDR_STATUS 8'h08
`define SSA_CTRL_TRUNK 0
`define SSA_CTRL_FALLOVER 1
`define SSA_CTRL_RST 2'h0
`define SSA_BLINK_RST 8'h19
`define SSA_ST_BOOT 0
`define SSA_ST_MAJOR 1
`define SSA_ST_MINOR 2
`define SSA_ST_SERVICE 3
`define SSA_ST_FALLBACK 4
`define SSA_ST_BEEP 5
`define SSA_ST_SEQ_LO 6
`define SSA_ST_SEQ_HI 7

// ----------------------------------------
// pin vector indices
// ----------------------------------------
`define SSA_NIN 21
`define SSA_IN_RX_UNLOCK 0
`define SSA_IN_TX_UNLOCK 1
`define SSA_IN_AMP_FAIL 2
`define SSA_IN_SHARP_CUT 3
`define SSA_IN_SELFTEST 4
`define SSA_IN_MAINS 5
`define SSA_IN_EXC_METER 6
`define SSA_IN_RX_METER 7
`define SSA_IN_LOOPBACK 8
`define SSA_IN_BAD_CHAN 9
`define SSA_IN_INTERCOM 10
`define SSA_IN_ACCESS 11
`define SSA_IN_PWR_CTRL 12
`define SSA_IN_SQUELCH 13
`define SSA_IN_FB_DIS 14
`define SSA_IN_SVC_KEY 15
`define SSA_IN_BOOT 16
`define SSA_IN_RX_ACT 17
`define SSA_IN_TRUNK_DATA 18
`define SSA_IN_AMP_KEYED 19
`define SSA_IN_CUTBACK 20

`endif

/* core/ssa_pkg.sv */
// types shared by the station status annunciator
`default_nettype none
package ssa_pkg;
    typedef logic [31:0] ssa_word_t;
    typedef enum logic [1:0] {SEQ_LAMP, SEQ_DARK, SEQ_RED, SEQ_RUN} ssa_seq_t;
    typedef enum logic [1:0] {BP_IDLE, BP_ON, BP_GAP} ssa_beep_t;
endpackage
`default_nettype wire

/* core/ssa_tick.sv */
// one-cycle tick enable divided down from the system clock
`default_nettype none
module ssa_tick #(
    parameter int CYCLES = 500000
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // tick
    output logic tick
);
    localparam int W = $clog2(CYCLES + 1);
    logic [W-1:0] cnt_q;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else if (cnt_q == W'(CYCLES - 1)) begin
            cnt_q <= '0;
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule // ssa_tick
`default_nettype wire

/* dv/ssa_panel_model.sv */
// front panel lamp and service speaker model for the annunciator bench
`default_nettype none
module ssa_panel_model (
    // clock
    input wire logic sys_clk,
    // lamps and speaker from the annunciator
    input wire logic [4:0] lamps,
    input wire logic beep,
    // what an observer at the panel sees and hears
    output logic [4:0] lit,
    output logic [31:0] gap,
    output logic [31:0] beep_len,
    output logic [31:0] rises
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] now = 32'h0000_0000;
    logic [31:0] last = 32'h0000_0000;
    logic [31:0] hi = 32'h0000_0000;
    logic prev = 1'b0;
    assign lit = lamps;
    // ------------------------------------
    // beep timing: rise to rise gap and tone length in clocks
    // ------------------------------------
    initial begin
        gap = 32'h0000_0000;
        beep_len = 32'h0000_0000;
        rises = 32'h0000_0000;
    end
    always @(posedge sys_clk) begin
        now <= now + 1;
        prev <= beep;
        if (beep === 1'b1 && !prev) begin
            gap <= now - last;
            last <= now;
            rises <= rises + 1;
            hi <= 1;
        end else if (beep === 1'b1) begin
            hi <= hi + 1;
        end else if (prev) begin
            beep_len <= hi;
        end
    end
endmodule // ssa_panel_model
`default_nettype wire

/* dv/test_ssa_annunciator.sv */
// self-checking bench for the station status annunciator
`include "ssa_regs.svh"
`default_nettype none
module test_ssa_annunciator;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TK = 10;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [20:0] p = 21'h00_0000;
    wire [31:0] reg_rdata;
    wire [4:0] lamps;
    wire [4:0] lit;
    wire beep;
    wire [31:0] gap;
    wire [31:0] beep_len;
    wire [31:0] rises;
    int err_count = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [30:0] rows [6];
    ssa_annunciator #(.TICK_CYCLES(TK)) dut_u (
        .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_synth_unlock(p[0]), .tx_synth_unlock(p[1]), .amp_fail(p[2]),
        .sharp_cutback(p[3]), .self_test_fail(p[4]), .mains_loss(p[5]),
        .exciter_meter_low(p[6]), .receiver_meter_low(p[7]), .loopback_fail(p[8]),
        .invalid_channel(p[9]), .intercom(p[10]), .access_disable(p[11]),
        .power_control_disable(p[12]), .tone_squelch_disable(p[13]),
        .fallback_disable(p[14]), .service_transmit_key(p[15]), .boot_mode(p[16]),
        .rx_unsquelched(p[17]), .trunk_tx_data(p[18]), .amp_keyed(p[19]),
        .power_cutback(p[20]), .health_red(lamps[4]), .health_green(lamps[3]),
        .rx_active_led(lamps[2]), .fallback_led(lamps[1]),
        .amplifier_keyed_indicator(lamps[0]), .speaker_beep(beep));
    ssa_panel_model panel_u (.sys_clk(sys_clk), .lamps(lamps), .beep(beep), .lit(lit),
        .gap(gap), .beep_len(beep_len), .rises(rises));
    // ------------------------------------
    // helpers: lamp codes 0 off, 1 steady, 2 flashing; red, green, rx, fallback, amp
    // ------------------------------------
    initial forever #10 sys_clk = ~sys_clk;
    function automatic logic [9:0] e(input int r, g, x, f, a);
        return {r[1:0], g[1:0], x[1:0], f[1:0], a[1:0]};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic obs(input logic [9:0] x);
        int n [5] = '{default: 0};
        logic [9:0] g;
        repeat (6) @(posedge sys_clk);
        repeat (40) begin
            @(posedge sys_clk);
            #1;
            for (int i = 0; i < 5; i++) n[i] += lit[i] === 1'b1 ? 1 : lit[i] === 1'b0 ? 0 : 99;
        end
        for (int i = 0; i < 5; i++)
            g[2*i +: 2] = n[i] > 40 ? 2'h3 : n[i] == 0 ? 2'h0 : n[i] == 40 ? 2'h1 : 2'h2;
        chk({22'h0, g}, {22'h0, x});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, x);
    endtask
    task automatic wait_rise;
        logic [31:0] r0;
        r0 = rises;
        for (int k = 0; k < 12000 && rises == r0; k++) @(posedge sys_clk);
        #1;
    endtask
    task automatic print_verdict;
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_count++;
            print_verdict();
        end
    end
    // ------------------------------------
    // main sequence
    // ------------------------------------
    initial begin
        rows = '{{21'h00_0000, e(0, 1, 0, 0, 0)}, {21'h03_0002, e(2, 2, 1, 0, 0)},
            {21'h00_0422, e(1, 0, 0, 0, 0)}, {21'h08_0420, e(2, 0, 0, 0, 1)},
            {21'h18_0400, e(0, 2, 0, 0, 2)}, {21'h02_0000, e(0, 1, 1, 0, 0)}};
        // conditions at power-up must not disturb the lamp sequence
        p <= 21'h0a_0002;
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(`SSA_ADDR_CTRL, 32'h0000_0000);
        rd(`SSA_ADDR_BLINK, 32'h0000_0019);
        rd(8'h0c, 32'h0000_0000);
        repeat (1500) @(posedge sys_clk);
        obs(e(1, 1, 1, 1, 1));
        repeat (6000) @(posedge sys_clk);
        obs(e(0, 0, 0, 0, 0));
        repeat (12000) @(posedge sys_clk);
        obs(e(1, 0, 0, 0, 0));
        repeat (4800) @(posedge sys_clk);
        wr(`SSA_ADDR_BLINK, 32'h0000_0002);
        for (int r = 0; r < 6; r++) begin
            @(posedge sys_clk);
            p <= rows[r][30:10];
            obs(rows[r][9:0]);
        end
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            p <= 21'h1 << i;
            obs(e(i < 5 ? 1 : i < 10 ? 2 : 0, i > 9 ? 2 : 0, 0, 0, 0));
        end
        @(posedge sys_clk);
        p <= 21'h00_0000;
        wr(`SSA_ADDR_CTRL, 32'h0000_0001);
        repeat (1100) @(posedge sys_clk);
        obs(e(0, 1, 0, 2, 0));
        rd(`SSA_ADDR_STATUS, 32'h0000_00d0);
        repeat (150) begin
            @(posedge sys_clk);
            p[18] <= ~p[18];
            repeat (8) @(posedge sys_clk);
        end
        obs(e(0, 1, 0, 0, 0));
        wr(`SSA_ADDR_CTRL, 32'h0000_0002);
        @(posedge sys_clk);
        p <= 21'h00_0020;
        wait_rise();
        wait_rise();
        chk(gap, 32'h0000_2710);
        chk(beep_len, 32'h0000_0064);
        @(posedge sys_clk);
        p <= 21'h08_0024;
        for (int k = 0; k < 5 && gap != 32'h0000_07d0; k++) wait_rise();
        chk(gap, 32'h0000_07d0);
        wait_rise();
        chk(gap, 32'h0000_00c8);
        wait_rise();
        chk(gap, 32'h0000_1e78);
        print_verdict();
    end
endmodule // test_ssa_annunciator
`default_nettype wire
